// ===== ssef_flags.sv
`timescale 1ns/1ps
// Contract
// RULE1: Read request for 0x49 answers 0x06, echoed 0xC9, one value byte.
// RULE2: Key status bit 1 shows volatile key loaded, bit 2 stored key.
// RULE3: Key status at 0xC9 is read-only; bits 0 and 3-7 reserved.
// RULE4: Read-only pairing status at 0xCA reflects pairing activity since reset.
// RULE5: Three event-flag bytes: byte2 at 0xCD, byte1 at 0xCE, byte0 at 0xCF.
// RULE6: Each listed event sets its own dedicated flag bit.
// RULE7: Alert line high when an enabled flag is set and legacy mask zero.
// RULE8: Reading a flag register never changes it.
// RULE9: Write stores AND of current value and written value.
// RULE10: Host writes only clear flags; some flags also clear internally.
// RULE11: Byte1 bit0 set when a packet is sent, after acknowledge if enabled.
// RULE12: Byte1 bit1 high while received bytes await delivery; clears when drained.
// RULE13: Byte1 bit2 set on plaintext packet, only with plaintext accepted.
// RULE14: Byte1 bit3 set when encrypted sequence number decreased.
// RULE15: Byte1 bit4 set when encrypted sequence number skipped ahead.
// RULE16: Byte1 bit5 set when a pairing operation begins.
// RULE17: Byte0 bits 0,1,2: UART overflow, radio overflow, register write failure.
// RULE18: Byte0 bit3 missing acknowledge after retries, bit6 wrong acknowledge sequence.
// RULE19: Byte0 bit4 payload CRC, bit5 header CRC, bit7 unsupported frame.
// RULE20: Byte2 and byte1 bits 6-7 are reserved, no events.
// RULE21: Flush receive buffer command clears the receive-pending flag.
// RULE22: An all-zero key means no key present.
// RULE23: Reserved bits read zero and ignore writes.
// RULE24: Pairing status is an 8-bit value loaded by pairing logic, reset zero.
module ssef_flags #(
	parameter int KEY_W = 128
) (
	// Clock and reset
	input  wire logic                 ref_clk_i,
	input  wire logic                 resetn_i,
	// Decoded command byte stream from the UART receiver
	input  wire ssef_pkg::ssef_byte_t rx_byte_i,
	// Answer byte stream to the UART transmitter
	output logic [7:0]                tx_data_o,
	output logic                      tx_valid_o,
	input  wire logic                 tx_ready_i,
	// Event pulses from the packet machinery
	input  wire ssef_pkg::ssef_ev0_t  ev0_i,
	input  wire ssef_pkg::ssef_ev1_t  ev1_i,
	input  wire logic                 rx_pending_i,
	input  wire logic                 flush_receive_buffer_command_i,
	// Configuration from neighbouring registers
	input  wire logic                 accept_plaintext_option_i,
	input  wire logic                 pairing_active_i,
	input  wire logic [23:0]          extended_alert_enable_i,
	input  wire logic [7:0]           legacy_alert_mask_i,
	// Key storage and pairing state
	input  wire logic [KEY_W-1:0]     volatile_key_i,
	input  wire logic [KEY_W-1:0]     stored_key_i,
	input  wire logic                 pairing_status_load_i,
	input  wire logic [7:0]           pairing_status_value_i,
	// Alert output
	output logic                      alert_status_line_o
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SIZE,
		ST_BODY
	} ssef_state_t;

	// Frame parser state
	ssef_state_t state_reg;
	ssef_state_t state_next;
	logic [7:0]  remain_reg;
	logic [7:0]  remain_next;
	logic        esc_reg;
	logic        esc_next;
	logic [1:0]  idx_reg;
	logic [1:0]  idx_next;
	logic        is_read_reg;
	logic        is_read_next;
	logic [7:0]  addr_reg;
	logic [7:0]  addr_next;
	logic [7:0]  val_reg;
	logic [7:0]  val_next;
	logic        done_reg;
	logic        done_next;

	// Register file
	logic [7:0]  flags0_reg;
	logic [7:0]  flags0_next;
	logic [7:0]  flags1_reg;
	logic [7:0]  flags1_next;
	logic [7:0]  key_status_reg;
	logic [7:0]  key_status_next;
	logic [7:0]  pairing_status_reg;
	logic [7:0]  pairing_status_next;
	logic        pend_prev_reg;
	logic        alert_reg;
	logic        alert_next;

	// Answer queue
	logic [7:0]  tx_buf_reg [3];
	logic [7:0]  tx_buf_next [3];
	logic [1:0]  tx_cnt_reg;
	logic [1:0]  tx_cnt_next;
	logic        tx_valid_reg;
	logic        tx_valid_next;

	// One-hot byte mask for a field position
	function automatic logic [7:0] bit_mask(input int pos);
		bit_mask = 8'h01 << pos;
	endfunction

	// Keep mask of a host write: the written value if this byte is hit, else all ones
	function automatic logic [7:0] keep_mask(input logic hit, input logic [7:0] value);
		keep_mask = hit ? value : 8'hff;
	endfunction

	// Clears first, then events, so an event never loses to a clear in its cycle
	function automatic logic [7:0] flag_update(input logic [7:0] cur,
	                                           input logic [7:0] keep,
	                                           input logic [7:0] set,
	                                           input logic [7:0] impl);
		flag_update = ((cur & keep) | set) & impl;
	endfunction

	// Byte decoding
	wire         in_byte     = rx_byte_i.valid;
	wire  [7:0]  in_data     = rx_byte_i.data;
	wire         is_header   = in_byte && (in_data == ssef_pkg::FRAME_HEADER);
	wire         is_escape   = !esc_reg && (in_data == ssef_pkg::FRAME_ESCAPE);
	wire  [7:0]  dec_data    = esc_reg ? (in_data | ssef_pkg::ESCAPE_OR) : in_data;
	wire         body_byte   = in_byte && !is_header && (state_reg == ST_BODY);
	wire         dec_valid   = body_byte && !is_escape;
	wire         last_byte   = body_byte && (remain_reg == 8'h01);

	// Command execution, one cycle after the last frame byte
	wire         tx_busy     = (tx_cnt_reg != 2'd0);
	wire         hit_key     = (addr_reg == ssef_pkg::ADDR_KEY_STATUS);
	wire         hit_pair    = (addr_reg == ssef_pkg::ADDR_PAIR_STATUS);
	wire         hit_f2      = (addr_reg == ssef_pkg::ADDR_FLAGS2);
	wire         hit_f1      = (addr_reg == ssef_pkg::ADDR_FLAGS1);
	wire         hit_f0      = (addr_reg == ssef_pkg::ADDR_FLAGS0);
	wire         hit_any     = hit_key || hit_pair || hit_f2 || hit_f1 || hit_f0;
	wire         hit_flags   = hit_f2 || hit_f1 || hit_f0;
	wire         exec        = done_reg && hit_any && (idx_reg == 2'd2);
	// A read answer is queued whole or not at all
	wire         do_read     = exec && is_read_reg && !tx_busy;
	wire         do_write    = exec && !is_read_reg;
	// Writes to read-only status, or while pairing locks the registers, fail
	wire         write_ok    = do_write && hit_flags && !pairing_active_i;  // see RULE3
	wire         write_fail  = do_write && (!hit_flags || pairing_active_i); // see RULE17
	wire         write_ack   = write_ok && !tx_busy;

	// Read value selection; reads have no side effect on any flag
	wire  [7:0]  read_value  = hit_key  ? key_status_reg :                    // see RULE1
	                           hit_pair ? pairing_status_reg :                // see RULE4
	                           hit_f1   ? flags1_reg :                        // see RULE8
	                           hit_f0   ? flags0_reg :
	                           (ssef_pkg::FLAGS2_IMPL & ssef_pkg::BYTE_RESET); // see RULE20

	// Host clear masks: all ones unless this byte is written
	wire  [7:0]  wmask0      = keep_mask(write_ok && hit_f0, val_reg);        // see RULE9
	wire  [7:0]  wmask1      = keep_mask(write_ok && hit_f1, val_reg);        // see RULE9

	// Set terms per bit, each event on its own bit
	wire  [7:0]  set0        = {ev0_i.unsupported_frame_flag,                 // see RULE19
	                            ev0_i.acknowledge_sequence_error_flag,        // see RULE18
	                            ev0_i.header_crc_error_flag,                  // see RULE19
	                            ev0_i.payload_crc_error_flag,                 // see RULE19
	                            ev0_i.missing_acknowledge_flag,               // see RULE18
	                            ev0_i.register_write_failure_flag | write_fail, // see RULE17
	                            ev0_i.radio_buffer_overflow_flag,             // see RULE17
	                            ev0_i.uart_buffer_overflow_flag};             // see RULE17
	wire  [7:0]  set1;
	// A flush beats the pending level in its own cycle
	wire         pend_set    = rx_pending_i && !flush_receive_buffer_command_i;
	wire         pend_clr    = (pend_prev_reg && !rx_pending_i) || flush_receive_buffer_command_i;
	wire  [7:0]  int_clr1    = pend_clr ? bit_mask(ssef_pkg::F1_RX_PENDING) : 8'h00; // see RULE21

	assign set1[ssef_pkg::F1_PACKET_SENT]  = ev1_i.packet_sent_flag;          // see RULE11
	assign set1[ssef_pkg::F1_RX_PENDING]   = pend_set;                        // see RULE12
	assign set1[ssef_pkg::F1_PLAINTEXT]    = ev1_i.plaintext_packet_flag
	                                         && accept_plaintext_option_i;    // see RULE13
	assign set1[ssef_pkg::F1_SEQ_DECREASE] = ev1_i.sequence_decrease_flag;    // see RULE14
	assign set1[ssef_pkg::F1_SEQ_GAP]      = ev1_i.sequence_gap_flag;         // see RULE15
	assign set1[ssef_pkg::F1_PAIRING]      = ev1_i.pairing_started_flag;      // see RULE16
	assign set1[7:6]                       = 2'b00;                           // see RULE20

	// Set wins over a clear arriving in the same cycle, so no event is lost
	assign flags0_next = flag_update(flags0_reg, wmask0, set0,
	                                 ssef_pkg::FLAGS0_IMPL);                  // see RULE10
	assign flags1_next = flag_update(flags1_reg, wmask1 & ~int_clr1, set1,
	                                 ssef_pkg::FLAGS1_IMPL);                  // see RULE23

	// Key presence: an all-zero key counts as no key
	wire         vol_key_set = |volatile_key_i;                               // see RULE22
	wire         nv_key_set  = |stored_key_i;                                 // see RULE22
	assign key_status_next = (bit_mask(ssef_pkg::KEY_VOLATILE_BIT) & {8{vol_key_set}}
	                         | bit_mask(ssef_pkg::KEY_STORED_BIT) & {8{nv_key_set}})
	                         & ssef_pkg::KEY_STATUS_IMPL;                     // see RULE2

	assign pairing_status_next = pairing_status_load_i ? pairing_status_value_i
	                                                   : pairing_status_reg;  // see RULE24

	// Byte 2 holds no events, so it never contributes to the alert
	wire  [23:0] all_flags   = {8'h00, flags1_reg, flags0_reg};
	assign alert_next = (|(all_flags & extended_alert_enable_i))
	                    && (legacy_alert_mask_i == 8'h00);                    // see RULE7

	// Frame parser: header restarts a frame anywhere, since bodies escape 0xff
	always_comb begin
		state_next   = state_reg;
		remain_next  = remain_reg;
		esc_next     = esc_reg;
		idx_next     = idx_reg;
		is_read_next = is_read_reg;
		addr_next    = addr_reg;
		val_next     = val_reg;
		done_next    = 1'b0;
		if (is_header) begin
			state_next = ST_SIZE;
		end else if (in_byte) begin
			case (state_reg)
				ST_SIZE: begin
					remain_next  = in_data;
					esc_next     = 1'b0;
					idx_next     = 2'd0;
					is_read_next = 1'b0;
					// Oversized or empty frames are dropped whole
					if ((in_data == 8'h00) || (in_data > ssef_pkg::SIZE_MAX)) begin
						state_next = ST_IDLE;
					end else begin
						state_next = ST_BODY;
					end
				end
				ST_BODY: begin
					remain_next = remain_reg - 8'h01;
					esc_next    = is_escape;
					if (dec_valid && (idx_reg == 2'd0)) begin
						is_read_next = (dec_data == ssef_pkg::READ_COMMAND);
						addr_next    = dec_data;
						idx_next     = 2'd1;
					end else if (dec_valid && (idx_reg == 2'd1)) begin
						// A read names the address with the top bit dropped
						if (is_read_reg) begin
							addr_next = dec_data | ssef_pkg::ESCAPE_OR; // see RULE1
						end else begin
							val_next = dec_data;
						end
						idx_next = 2'd2;
					end else if (dec_valid) begin
						idx_next = 2'd3;
					end
					if (last_byte) begin
						state_next = ST_IDLE;
						done_next  = 1'b1;
					end
				end
				default: begin
					state_next = ST_IDLE;
				end
			endcase
		end
	end

	// Answer queue: a read that finds an answer still going out is dropped; a write is still applied, unacknowledged
	always_comb begin
		tx_buf_next[0] = tx_buf_reg[0];
		tx_buf_next[1] = tx_buf_reg[1];
		tx_buf_next[2] = tx_buf_reg[2];
		tx_cnt_next    = tx_cnt_reg;
		if (do_read) begin
			tx_buf_next[0] = ssef_pkg::ACK_BYTE;                              // see RULE1
			tx_buf_next[1] = addr_reg;
			tx_buf_next[2] = read_value;
			tx_cnt_next    = ssef_pkg::READ_ANSWER_LEN;
		end else if (write_ack) begin
			tx_buf_next[0] = ssef_pkg::ACK_BYTE;
			tx_cnt_next    = ssef_pkg::WRITE_ANSWER_LEN;
		end else if (tx_valid_reg && tx_ready_i) begin
			// The top slot is left stale after a pop; the count keeps it unread
			tx_buf_next[0] = tx_buf_reg[1];
			tx_buf_next[1] = tx_buf_reg[2];
			tx_cnt_next    = tx_cnt_reg - 2'd1;
		end
	end

	assign tx_valid_next = (tx_cnt_next != 2'd0);

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg   <= ST_IDLE;
			remain_reg  <= ssef_pkg::BYTE_RESET;
			esc_reg     <= 1'b0;
			idx_reg     <= 2'd0;
			is_read_reg <= 1'b0;
			addr_reg    <= ssef_pkg::BYTE_RESET;
			val_reg     <= ssef_pkg::BYTE_RESET;
			done_reg    <= 1'b0;
		end else begin
			state_reg   <= state_next;
			remain_reg  <= remain_next;
			esc_reg     <= esc_next;
			idx_reg     <= idx_next;
			is_read_reg <= is_read_next;
			addr_reg    <= addr_next;
			val_reg     <= val_next;
			done_reg    <= done_next;
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			flags0_reg         <= ssef_pkg::BYTE_RESET;
			flags1_reg         <= ssef_pkg::BYTE_RESET;
			key_status_reg     <= ssef_pkg::BYTE_RESET;
			pairing_status_reg <= ssef_pkg::BYTE_RESET;
			pend_prev_reg      <= 1'b0;
			alert_reg          <= 1'b0;
		end else begin
			flags0_reg         <= flags0_next;                                // see RULE6
			flags1_reg         <= flags1_next;                                // see RULE5
			key_status_reg     <= key_status_next;
			pairing_status_reg <= pairing_status_next;
			pend_prev_reg      <= rx_pending_i;
			alert_reg          <= alert_next;
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tx_buf_reg[0] <= ssef_pkg::BYTE_RESET;
			tx_buf_reg[1] <= ssef_pkg::BYTE_RESET;
			tx_buf_reg[2] <= ssef_pkg::BYTE_RESET;
			tx_cnt_reg    <= 2'd0;
			tx_valid_reg  <= 1'b0;
		end else begin
			tx_buf_reg[0] <= tx_buf_next[0];
			tx_buf_reg[1] <= tx_buf_next[1];
			tx_buf_reg[2] <= tx_buf_next[2];
			tx_cnt_reg    <= tx_cnt_next;
			tx_valid_reg  <= tx_valid_next;
		end
	end

	assign tx_data_o           = tx_buf_reg[0];
	assign tx_valid_o          = tx_valid_reg;
	assign alert_status_line_o = alert_reg;

endmodule // ssef_flags

// ===== ssef_pkg.sv
package ssef_pkg;

	// Command framing bytes
	localparam logic [7:0] FRAME_HEADER  = 8'hff;
	localparam logic [7:0] FRAME_ESCAPE  = 8'hfe;
	localparam logic [7:0] READ_COMMAND  = 8'hfe;
	localparam logic [7:0] ACK_BYTE      = 8'h06;
	localparam logic [7:0] ESCAPE_OR     = 8'h80;
	localparam logic [7:0] SIZE_MAX      = 8'h10;

	// Volatile register addresses
	localparam logic [7:0] ADDR_KEY_STATUS  = 8'hc9;
	localparam logic [7:0] ADDR_PAIR_STATUS = 8'hca;
	localparam logic [7:0] ADDR_FLAGS2      = 8'hcd;
	localparam logic [7:0] ADDR_FLAGS1      = 8'hce;
	localparam logic [7:0] ADDR_FLAGS0      = 8'hcf;

	// Implemented bits; all others read as zero
	localparam logic [7:0] KEY_STATUS_IMPL = 8'h06;
	localparam logic [7:0] FLAGS0_IMPL     = 8'hff;
	localparam logic [7:0] FLAGS1_IMPL     = 8'h3f;
	localparam logic [7:0] FLAGS2_IMPL     = 8'h00;

	// Field positions
	localparam int KEY_VOLATILE_BIT = 1;
	localparam int KEY_STORED_BIT   = 2;
	localparam int F1_PACKET_SENT   = 0;
	localparam int F1_RX_PENDING    = 1;
	localparam int F1_PLAINTEXT     = 2;
	localparam int F1_SEQ_DECREASE  = 3;
	localparam int F1_SEQ_GAP       = 4;
	localparam int F1_PAIRING       = 5;

	// Reset values
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// Answer lengths in bytes
	localparam logic [1:0] READ_ANSWER_LEN  = 2'd3;
	localparam logic [1:0] WRITE_ANSWER_LEN = 2'd1;

	// One received command byte
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} ssef_byte_t;

	// Event pulses for flag byte 0, bit 0 is the last field
	typedef struct packed {
		logic unsupported_frame_flag;
		logic acknowledge_sequence_error_flag;
		logic header_crc_error_flag;
		logic payload_crc_error_flag;
		logic missing_acknowledge_flag;
		logic register_write_failure_flag;
		logic radio_buffer_overflow_flag;
		logic uart_buffer_overflow_flag;
	} ssef_ev0_t;

	// Event pulses for flag byte 1
	typedef struct packed {
		logic pairing_started_flag;
		logic sequence_gap_flag;
		logic sequence_decrease_flag;
		logic plaintext_packet_flag;
		logic packet_sent_flag;
	} ssef_ev1_t;

endpackage

// ===== ssef_flags_chk.sv
`timescale 1ns/1ps
module ssef_flags_chk (
	// Clock and reset
	input  wire logic                 ref_clk_i,
	input  wire logic                 resetn_i,
	// Command and answer streams
	input  wire ssef_pkg::ssef_byte_t rx_byte_i,
	input  wire logic [7:0]           tx_data_o,
	input  wire logic                 tx_valid_o,
	input  wire logic                 tx_ready_i,
	// Events, configuration and alert
	input  wire ssef_pkg::ssef_ev0_t  ev0_i,
	input  wire logic                 pairing_active_i,
	input  wire logic [23:0]          extended_alert_enable_i,
	input  wire logic [7:0]           legacy_alert_mask_i,
	input  wire logic                 alert_status_line_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	sequence s_byte(b); rx_byte_i.valid && rx_byte_i.data == b; endsequence
	sequence s_head; s_byte(8'hff) ##1 s_byte(8'h03) ##1 s_byte(8'hfe); endsequence
	sequence s_rd_key; s_head ##1 s_byte(8'hfe) ##1 s_byte(8'h49); endsequence
	sequence s_wr_key; s_head ##1 s_byte(8'h49) ##1 rx_byte_i.valid; endsequence
	sequence s_wr_flags0; s_head ##1 s_byte(8'h4f) ##1 rx_byte_i.valid; endsequence

	property p_rd_key;
		s_rd_key ##0 !tx_valid_o |-> ##2 (tx_valid_o && tx_data_o == 8'h06);
	endproperty
	a_rd_key: assert property (p_rd_key) else $error("key status read not acknowledged");
	property p_wr_ack;
		s_wr_flags0 ##0 (!tx_valid_o && !pairing_active_i) ##1 !pairing_active_i
			|-> ##1 (tx_valid_o && tx_data_o == 8'h06);
	endproperty
	a_wr_ack: assert property (p_wr_ack) else $error("flag write not acknowledged");
	property p_wr_lock;
		s_wr_flags0 ##0 (!tx_valid_o && pairing_active_i) |=> !tx_valid_o [*4];
	endproperty
	a_wr_lock: assert property (p_wr_lock) else $error("write during pairing answered");
	property p_wr_ro;
		s_wr_key ##0 !tx_valid_o |=> !tx_valid_o [*4];
	endproperty
	a_wr_ro: assert property (p_wr_ro) else $error("write to key status answered");
	property p_stand;
		tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o);
	endproperty
	a_stand: assert property (p_stand) else $error("answer byte dropped while stalled");
	property p_leg_off;
		legacy_alert_mask_i != 8'h00 |=> !alert_status_line_o;
	endproperty
	a_leg_off: assert property (p_leg_off) else $error("alert with legacy mask set");
	property p_en_off;
		extended_alert_enable_i == 24'h000000 |=> !alert_status_line_o;
	endproperty
	a_en_off: assert property (p_en_off) else $error("alert with no enable");
	// Two quiet cycles cover the flag update and the registered alert
	property p_alert_on;
		((ev0_i & extended_alert_enable_i[7:0]) != 8'h00 && legacy_alert_mask_i == 8'h00)
			##1 ($stable(extended_alert_enable_i) && legacy_alert_mask_i == 8'h00) [*2]
			|=> alert_status_line_o;
	endproperty
	a_alert_on: assert property (p_alert_on) else $error("enabled event gave no alert");
endmodule // ssef_flags_chk

bind ssef_flags ssef_flags_chk u_chk (
	.ref_clk_i              (ref_clk_i),
	.resetn_i               (resetn_i),
	.rx_byte_i              (rx_byte_i),
	.tx_data_o              (tx_data_o),
	.tx_valid_o             (tx_valid_o),
	.tx_ready_i             (tx_ready_i),
	.ev0_i                  (ev0_i),
	.pairing_active_i       (pairing_active_i),
	.extended_alert_enable_i(extended_alert_enable_i),
	.legacy_alert_mask_i    (legacy_alert_mask_i),
	.alert_status_line_o    (alert_status_line_o)
);

// ===== ssef_host.sv
`timescale 1ns/1ps
module ssef_host (
	// Clock
	input  wire logic            ref_clk_i,
	// Command and answer streams
	output ssef_pkg::ssef_byte_t rx_byte_o,
	input  wire logic [7:0]      tx_data_i,
	input  wire logic            tx_valid_i,
	output logic                 tx_ready_o
);
	logic       slow = 1'b0;
	logic [7:0] ans [$];

	initial begin
		rx_byte_o = '0;
		tx_ready_o = 1'b1;
	end
	// Slow mode stalls every other cycle so the answer must stand
	always @(posedge ref_clk_i) begin
		tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
		if (tx_valid_i && tx_ready_o) begin
			ans.push_back(tx_data_i);
		end
	end

	// Idle data is inverted so a stale byte is never mistaken for a new one
	task automatic frame(input logic [7:0] b [$]);
		ans.delete();
		foreach (b[i]) begin
			@(posedge ref_clk_i);
			rx_byte_o <= {1'b1, b[i]};
		end
		@(posedge ref_clk_i);
		rx_byte_o <= {1'b0, ~b[b.size()-1]};
		repeat (12) @(posedge ref_clk_i);
	endtask
	task automatic rd_raw(input logic [7:0] a);
		frame('{8'hff, 8'h03, 8'hfe, 8'hfe, a & 8'h7f});
	endtask
	task automatic wr_raw(input logic [7:0] a, input logic [7:0] v);
		if (v[7]) begin
			frame('{8'hff, 8'h04, 8'hfe, a & 8'h7f, 8'hfe, v & 8'h7f});
		end else begin
			frame('{8'hff, 8'h03, 8'hfe, a & 8'h7f, v});
		end
	endtask
endmodule // ssef_host

// ===== tb_security_status_and_event_flags.sv
`timescale 1ns/1ps
module tb_security_status_and_event_flags;
	logic                 ref_clk_i = 1'b0;
	logic                 resetn_i = 1'b0;
	ssef_pkg::ssef_byte_t rx_byte;
	logic [7:0]           tx_data;
	logic                 tx_valid;
	logic                 tx_ready;
	logic                 alert;
	logic                 rx_pend = 1'b0;
	logic                 flush = 1'b0;
	logic                 acc_pt = 1'b0;
	logic                 pair_act = 1'b0;
	logic                 pst_load = 1'b0;
	logic [7:0]           pst_val = 8'h00;
	logic [7:0]           leg = 8'h00;
	logic [23:0]          en = 24'h000000;
	logic [127:0]         vkey = '0;
	logic [127:0]         skey = '0;
	ssef_pkg::ssef_ev0_t  ev0 = '0;
	ssef_pkg::ssef_ev1_t  ev1 = '0;
	int                   errors = 0;
	int                   n_tests = 0;
	int                   ev1_bit [5] = '{0, 2, 3, 4, 5};

	always #20 ref_clk_i = ~ref_clk_i;

	ssef_flags u_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .rx_byte_i(rx_byte),
		.tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .ev0_i(ev0),
		.ev1_i(ev1), .rx_pending_i(rx_pend), .flush_receive_buffer_command_i(flush),
		.accept_plaintext_option_i(acc_pt), .pairing_active_i(pair_act),
		.extended_alert_enable_i(en), .legacy_alert_mask_i(leg), .volatile_key_i(vkey),
		.stored_key_i(skey), .pairing_status_load_i(pst_load),
		.pairing_status_value_i(pst_val), .alert_status_line_o(alert));
	ssef_host u_host (.ref_clk_i(ref_clk_i), .rx_byte_o(rx_byte), .tx_data_i(tx_data),
		.tx_valid_i(tx_valid), .tx_ready_o(tx_ready));

	task automatic give_verdict;
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		u_host.rd_raw(a);
		chk(8'(u_host.ans.size()), 8'h03);
		if (u_host.ans.size() == 3) begin
			chk(u_host.ans[0], ssef_pkg::ACK_BYTE);
			chk(u_host.ans[1], a);
			chk(u_host.ans[2], exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [7:0] n);
		u_host.wr_raw(a, v);
		chk(8'(u_host.ans.size()), n);
	endtask
	task automatic pulse(input logic [7:0] m0, input logic [4:0] m1);
		@(posedge ref_clk_i);
		ev0 <= ssef_pkg::ssef_ev0_t'(m0);
		ev1 <= ssef_pkg::ssef_ev1_t'(m1);
		@(posedge ref_clk_i);
		ev0 <= '0;
		ev1 <= '0;
	endtask

	initial begin
		#(40 * 6000);
		errors++;
		give_verdict();
	end

	initial begin
		repeat (2) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		rd(8'hc9, 8'h00);
		rd(8'hca, 8'h00);
		rd(8'hcd, 8'h00);
		rd(8'hce, 8'h00);
		rd(8'hcf, 8'h00);
		u_host.rd_raw(8'hd0);
		chk(8'(u_host.ans.size()), 8'h00);
		vkey <= 128'h1;
		rd(8'hc9, 8'h02);
		skey <= {1'b1, 127'h0};
		rd(8'hc9, 8'h06);
		wr(8'hc9, 8'h00, 8'h00);
		rd(8'hc9, 8'h06);
		rd(8'hcf, 8'h04);
		wr(8'hcf, 8'h00, 8'h01);
		en <= 24'hffffff;
		for (int i = 0; i < 8; i++) begin
			pulse(8'h01 << i, 5'h00);
			rd(8'hcf, 8'h01 << i);
			chk({7'h00, alert}, 8'h01);
			wr(8'hcf, ~(8'h01 << i), 8'h01);
			rd(8'hcf, 8'h00);
		end
		acc_pt <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			pulse(8'h00, 5'h01 << i);
			rd(8'hce, 8'h01 << ev1_bit[i]);
			wr(8'hce, 8'h00, 8'h01);
		end
		acc_pt <= 1'b0;
		pulse(8'h00, 5'h02);
		rd(8'hce, 8'h00);
		pulse(8'hff, 5'h00);
		wr(8'hcf, 8'h0f, 8'h01);
		wr(8'hcf, 8'hff, 8'h01);
		rd(8'hcf, 8'h0f);
		rd(8'hcf, 8'h0f);
		leg <= 8'h01;
		rd(8'hcd, 8'h00);
		chk({7'h00, alert}, 8'h00);
		leg <= 8'h00;
		en <= 24'hffff00;
		wr(8'hcd, 8'h00, 8'h01);
		chk({7'h00, alert}, 8'h00);
		en <= 24'h0000ff;
		wr(8'hcf, 8'h01, 8'h01);
		pair_act <= 1'b1;
		wr(8'hcf, 8'h00, 8'h00);
		pair_act <= 1'b0;
		rd(8'hcf, 8'h05);
		en <= 24'h000200;
		rx_pend <= 1'b1;
		rd(8'hce, 8'h02);
		chk({7'h00, alert}, 8'h01);
		flush <= 1'b1;
		@(posedge ref_clk_i);
		flush <= 1'b0;
		@(posedge ref_clk_i);
		#1;
		chk({7'h00, alert}, 8'h00);
		@(posedge ref_clk_i);
		rx_pend <= 1'b0;
		rd(8'hce, 8'h00);
		pst_val <= 8'h5a;
		pst_load <= 1'b1;
		@(posedge ref_clk_i);
		pst_load <= 1'b0;
		rd(8'hca, 8'h5a);
		u_host.slow <= 1'b1;
		rd(8'hc9, 8'h06);
		u_host.slow <= 1'b0;
		resetn_i <= 1'b0;
		@(posedge ref_clk_i);
		resetn_i <= 1'b1;
		rd(8'hca, 8'h00);
		give_verdict();
	end
endmodule // tb_security_status_and_event_flags
